/* File: logic/xlat_cache_regs.svh */
// offsets, field positions, reset values and counts of the translation cache
// Function
// - Pages above 256 bytes drop offset bits from tag compares.
// - Hit: equal page and function code, and job tag match or shared bit.
// - 64 entries, each a tag word paired with a data word.
// - New entry copies lock bit, cleared once 63 entries are locked.
// - Active-low inhibit output is the inverse of the stored inhibit bit.
// - Permitted write to unmodified entry sets entry and descriptor modified bits.
// - Fault entries never translate, give bus error; made for failed searches.
// - Entry write-protect holds protection accumulated over the search.
// - Allocate invalid entry first, else unlocked pseudo-LRU victim.
// - Each entry has valid and history bits; history steers replacement.
// - Compare only when enabled and not bus master; resolve on logical strobe.
// - CPU-space non-register cycles pass address through with inhibit.
// - Plain miss: bus error, halt, relinquish and search pulse all start on the same clock.
// - Read-modify-write miss asserts bus error only.
// - Single hit with bus: frame and inhibit, then bus error or strobe.
// - Without bus: signal as usual, hold strobe until bus regained.
// - Several hits: invalidate all matches, treat as miss.
// - Mode pin picks timing per cycle; synchronous strobe one clock after.
// - Asynchronous mode decides after the synchronised logical strobe.
// - Eight root pointer slots; new entries take current slot as job tag.
// - Known root pointer: adopt index, show it, clear flush flag.
// - Same address and direction, new limit or type: overwrite, purge, set flush.
// - Table miss: invalid or pseudo-LRU slot; reuse purges; adopt, show, flush.
`ifndef XLAT_CACHE_REGS_SVH
`define XLAT_CACHE_REGS_SVH
`define CTRL_OFS 8'h00
`define STATUS_OFS 8'h04
`define URP_HI_OFS 8'h08
`define URP_LO_OFS 8'h0C
`define FILL_TAG_OFS 8'h10
`define FILL_DATA_OFS 8'h14
`define MISS_INFO_OFS 8'h18
`define CTRL_EN_BIT 0
`define CTRL_PS_LSB 1
`define URP_LU_BIT 31
`define FILL_SG_BIT 7
`define FILL_WPUP_BIT 6
`define FILL_CI_BIT 0
`define FILL_WP_BIT 1
`define FILL_M_BIT 2
`define FILL_LOCK_BIT 3
`define FILL_INV_BIT 4
`define FILL_SUP_BIT 6
`define FILL_RAL_BIT 7
`define RST_WORD 32'h00000000
`define ENTRY_NUM 64
`define RPT_NUM 8
`define LOCK_MAX 63
`define CPU_SPACE_FC 4'h7
`define DECISION_CYC 2
`endif

/* File: logic/xlat_cache_pkg.sv */
// types shared by the translation cache design
package xlat_cache_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOOK = 2'b01,
    ST_WAIT = 2'b10,
    ST_RESP = 2'b11
  } xlat_state_e;
  typedef enum logic [1:0] {
    OUT_PASS = 2'b00,
    OUT_GRANT = 2'b01,
    OUT_DENY = 2'b10,
    OUT_MISS = 2'b11
  } outcome_e;
  typedef struct packed {
    logic [23:0] page;
    logic [3:0] fc;
    logic [2:0] job;
    logic sg;
  } tag_s;
  typedef struct packed {
    logic [23:0] frame;
    logic ci;
    logic wp;
    logic m;
    logic lock;
    logic fault;
  } data_s;
  typedef struct packed {
    logic [31:0] addr;
    logic lu;
    logic [14:0] limit;
    logic [1:0] dt;
  } root_ptr_s;
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0] fc;
    logic write;
    logic rmw;
  } cycle_s;
endpackage

/* File: logic/victim_picker.sv */
// replacement choice: first invalid slot, else oldest unlocked, else any unlocked
`timescale 1ns/1ps
module victim_picker #(
  parameter int N = 64,
  parameter int W = 6
) (
  input wire logic [N-1:0] valid_in,
  input wire logic [N-1:0] locked_in,
  input wire logic [N-1:0] recent_in,
  output logic [W-1:0] idx_out,
  output logic found_out,
  output logic invalid_out
);
  wire [N-1:0] cand_free = ~valid_in;
  wire [N-1:0] cand_old = valid_in & ~locked_in & ~recent_in;
  wire [N-1:0] cand_any = valid_in & ~locked_in;
  wire [N-1:0] cand = (|cand_free) ? cand_free : ((|cand_old) ? cand_old : cand_any);

  // lowest index wins
  always_comb begin
    idx_out = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (cand[i]) begin
        idx_out = W'(i);
      end
    end
  end

  assign found_out = |cand;
  assign invalid_out = |cand_free;
endmodule

/* File: logic/xlat_cache.sv */
// translation cache: lookup, decision timing, replacement and task alias table
`timescale 1ns/1ps
`include "xlat_cache_regs.svh"

module xlat_cache
  import xlat_cache_pkg::*;
#(
  parameter int ENTRIES = `ENTRY_NUM,
  parameter int DECISION_CYCLES = `DECISION_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [31:0] logical_addr_in,
  input wire logic [3:0] function_code_in,
  input wire logic read_write_in,
  input wire logic logical_address_strobe_n_in,
  input wire logic read_modify_write_cycle_n_in,
  input wire logic timing_mode_select_in,
  input wire logic reg_select_in,
  input wire logic self_master_in,
  input wire logic bus_owned_in,
  output logic [31:0] physical_addr_out,
  output logic physical_addr_strobe_n_out,
  output logic cache_inhibit_n_out,
  output logic bus_error_n_out,
  output logic halt_n_out,
  output logic bus_relinquish_request_n_out,
  output logic search_start_out,
  output logic modified_set_out,
  output logic [23:0] modified_page_out
);
  localparam int IW = $clog2(ENTRIES);
  localparam int CW = $clog2(ENTRIES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // logical strobe capture
  logic las_s1_ff;
  logic las_s2_ff;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      las_s1_ff <= 1'b0;
      las_s2_ff <= 1'b0;
    end else begin
      las_s1_ff <= ~logical_address_strobe_n_in;
      las_s2_ff <= las_s1_ff;
    end
  end
  // synchronous masters share our clock, so their strobe is read directly
  wire las_sync_mode = ~logical_address_strobe_n_in;
  wire las_act = timing_mode_select_in ? las_s2_ff : las_sync_mode;

  ////////////////////////////////////////////////////////////////////////////
  // register port
  logic ctrl_en_ff;
  logic [2:0] ctrl_ps_ff;
  logic [31:0] urp_hi_ff;
  logic [31:0] fill_tag_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rd_value;
  logic [2:0] job_ff;
  logic flush_ff;
  logic [27:0] miss_info_ff;
  logic [CW-1:0] lock_cnt;
  wire wr_ctrl = reg_wr_in && (reg_addr_in == `CTRL_OFS);
  wire wr_urp_hi = reg_wr_in && (reg_addr_in == `URP_HI_OFS);
  wire wr_fill_tag = reg_wr_in && (reg_addr_in == `FILL_TAG_OFS);
  wire rp_load = reg_wr_in && (reg_addr_in == `URP_LO_OFS);
  wire fill_req = reg_wr_in && (reg_addr_in == `FILL_DATA_OFS);

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl_en_ff <= 1'b0;
      ctrl_ps_ff <= 3'h0;
      urp_hi_ff <= `RST_WORD;
      fill_tag_ff <= `RST_WORD;
    end else begin
      if (wr_ctrl) begin
        ctrl_en_ff <= reg_wdata_in[`CTRL_EN_BIT];
        ctrl_ps_ff <= reg_wdata_in[`CTRL_PS_LSB +: 3];
      end
      if (wr_urp_hi) begin
        urp_hi_ff <= reg_wdata_in;
      end
      if (wr_fill_tag) begin
        fill_tag_ff <= reg_wdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cache storage and compare
  tag_s tag_ff [ENTRIES];
  data_s data_ff [ENTRIES];
  tag_s fill_tag;
  data_s fill_data;
  data_s hit_data;
  cycle_s cyc_ff;
  logic [ENTRIES-1:0] valid_ff;
  logic [ENTRIES-1:0] hist_ff;
  logic [ENTRIES-1:0] hit_vec;
  logic [ENTRIES-1:0] lock_vec;
  logic [ENTRIES-1:0] job_vec;
  logic [ENTRIES-1:0] kill_vec;
  logic [ENTRIES-1:0] fill_vec;
  logic [ENTRIES-1:0] touch_vec;
  logic [ENTRIES-1:0] mset_vec;
  logic [ENTRIES-1:0] hist_pre;
  logic [ENTRIES-1:0] nxt_valid;
  logic [ENTRIES-1:0] nxt_hist;
  logic [IW-1:0] vic_idx;
  logic vic_found;
  logic [2:0] rpt_new_idx;
  logic rpt_kill;

  wire [23:0] page_mask = 24'hFFFFFF << ctrl_ps_ff;

  for (genvar g = 0; g < ENTRIES; g++) begin : g_entry
    assign hit_vec[g] = valid_ff[g]
      && (((tag_ff[g].page ^ cyc_ff.addr[31:8]) & page_mask) == 24'h000000)
      && (tag_ff[g].fc == cyc_ff.fc)
      && ((tag_ff[g].job == job_ff) || tag_ff[g].sg);
    assign lock_vec[g] = valid_ff[g] && data_ff[g].lock;
    // shared entries survive a task purge
    assign job_vec[g] = valid_ff[g] && !tag_ff[g].sg && (tag_ff[g].job == rpt_new_idx);
    always_ff @(posedge ref_clk_in) begin
      if (fill_vec[g]) begin
        tag_ff[g] <= fill_tag;
        data_ff[g] <= fill_data;
      end else if (mset_vec[g]) begin
        data_ff[g].m <= 1'b1;
      end
    end
  end

  always_comb begin
    hit_data = '0;
    lock_cnt = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (hit_vec[i]) begin
        hit_data = hit_data | data_ff[i];
      end
      lock_cnt = lock_cnt + CW'(lock_vec[i]);
    end
  end

  wire lock_full = lock_cnt >= CW'(`LOCK_MAX);
  wire multi_hit = |(hit_vec & (hit_vec - ENTRIES'(1)));
  wire single_hit = (|hit_vec) && !multi_hit;

  victim_picker #(
    .N(ENTRIES),
    .W(IW)
  ) u_atc_victim (
    .valid_in(valid_ff),
    .locked_in(lock_vec),
    .recent_in(hist_ff),
    .idx_out(vic_idx),
    .found_out(vic_found),
    .invalid_out()
  );

  // new entry from the search result words
  assign fill_tag.page = fill_tag_ff[31:8];
  assign fill_tag.fc = fill_tag_ff[3:0];
  assign fill_tag.job = job_ff;
  assign fill_tag.sg = fill_tag_ff[`FILL_SG_BIT];
  assign fill_data.frame = reg_wdata_in[31:8];
  assign fill_data.ci = reg_wdata_in[`FILL_CI_BIT];
  assign fill_data.wp = reg_wdata_in[`FILL_WP_BIT] | fill_tag_ff[`FILL_WPUP_BIT];
  assign fill_data.m = reg_wdata_in[`FILL_M_BIT];
  assign fill_data.lock = reg_wdata_in[`FILL_LOCK_BIT] && !lock_full;
  // invalid descriptor, walk bus error, supervisor or read-level denial
  assign fill_data.fault = |reg_wdata_in[`FILL_RAL_BIT:`FILL_INV_BIT];
  assign fill_vec = (fill_req && vic_found) ? (ENTRIES'(1) << vic_idx) : '0;

  ////////////////////////////////////////////////////////////////////////////
  // lookup sequence
  xlat_state_e state_ff;
  xlat_state_e nxt_state;
  outcome_e outcome_ff;
  outcome_e nxt_outcome;
  logic [7:0] cnt_ff;
  logic [31:0] pa_ff;
  logic ci_ff;
  logic search_ff;
  logic mset_ff;
  logic [23:0] mpage_ff;
  cycle_s bus_cycle;

  wire wr_cycle = ~read_write_in | ~read_modify_write_cycle_n_in;
  assign bus_cycle = {logical_addr_in, function_code_in, wr_cycle, ~read_modify_write_cycle_n_in};
  wire reg_cycle = (function_code_in == `CPU_SPACE_FC) && reg_select_in;
  wire start = ctrl_en_ff && !self_master_in && las_act && !reg_cycle;
  wire look = (state_ff == ST_LOOK);
  wire cpu_space = (cyc_ff.fc == `CPU_SPACE_FC);
  wire wr_deny = cyc_ff.write && hit_data.wp;
  wire decide = (state_ff == ST_WAIT) && (cnt_ff == 8'h00) && las_act;
  wire [23:0] frame = (hit_data.frame & page_mask) | (cyc_ff.addr[31:8] & ~page_mask);

  always_comb begin
    if (cpu_space) begin
      nxt_outcome = OUT_PASS;
    end else if (single_hit && (hit_data.fault || wr_deny)) begin
      nxt_outcome = OUT_DENY;
    end else if (single_hit) begin
      nxt_outcome = OUT_GRANT;
    end else begin
      nxt_outcome = OUT_MISS;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_LOOK;
        end
      end
      ST_LOOK: begin
        nxt_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (!las_act) begin
          nxt_state = ST_IDLE;
        end else if (cnt_ff == 8'h00) begin
          nxt_state = ST_RESP;
        end
      end
      ST_RESP: begin
        if (!las_act) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_ff <= ST_IDLE;
      outcome_ff <= OUT_MISS;
      cnt_ff <= 8'h00;
      pa_ff <= `RST_WORD;
      ci_ff <= 1'b0;
      cyc_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_IDLE) begin
        cyc_ff <= bus_cycle;
      end
      if (look) begin
        outcome_ff <= nxt_outcome;
        cnt_ff <= 8'(DECISION_CYCLES - 1);
        pa_ff <= cpu_space ? cyc_ff.addr : {frame, cyc_ff.addr[7:0]};
        ci_ff <= cpu_space || (single_hit && hit_data.ci);
      end else if ((state_ff == ST_WAIT) && (cnt_ff != 8'h00)) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end

  // pulses toward the table walker and descriptor updater
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      search_ff <= 1'b0;
      mset_ff <= 1'b0;
      mpage_ff <= 24'h000000;
      miss_info_ff <= 28'h0000000;
    end else begin
      search_ff <= decide && (outcome_ff == OUT_MISS) && !cyc_ff.rmw;
      mset_ff <= |mset_vec;
      if (|mset_vec) begin
        mpage_ff <= cyc_ff.addr[31:8];
      end
      if (decide && (outcome_ff == OUT_MISS)) begin
        miss_info_ff <= {cyc_ff.addr[31:8], cyc_ff.fc};
      end
    end
  end

  // entry is re-looked up at decision time so a fill in between cannot misfire
  wire mset_go = decide && (outcome_ff == OUT_GRANT) && cyc_ff.write && !hit_data.m;
  assign mset_vec = mset_go ? hit_vec : '0;
  assign touch_vec = fill_vec | ((look && single_hit && !cpu_space) ? hit_vec : '0);
  assign kill_vec = ((look && multi_hit && !cpu_space) ? hit_vec : '0)
    | (rpt_kill ? job_vec : '0);
  assign nxt_valid = (valid_ff & ~kill_vec) | fill_vec;
  assign hist_pre = (hist_ff & ~kill_vec) | touch_vec;
  // age the history once every live unlocked entry has been used
  assign nxt_hist = (&(hist_pre | ~nxt_valid | lock_vec)) ? touch_vec : hist_pre;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      valid_ff <= '0;
      hist_ff <= '0;
    end else begin
      valid_ff <= nxt_valid;
      hist_ff <= nxt_hist;
    end
  end

  wire in_resp = (state_ff == ST_RESP);
  wire is_hit = (outcome_ff == OUT_GRANT) || (outcome_ff == OUT_DENY);
  wire grant_like = (outcome_ff == OUT_GRANT) || (outcome_ff == OUT_PASS);
  wire stall_req = in_resp && (outcome_ff == OUT_MISS) && !cyc_ff.rmw;

  assign physical_addr_out = pa_ff;
  assign cache_inhibit_n_out = ~(ci_ff && (((state_ff == ST_WAIT) && is_hit) || in_resp));
  // strobe waits for bus ownership while the master keeps asking
  assign physical_addr_strobe_n_out = ~(in_resp && grant_like && bus_owned_in);
  assign bus_error_n_out = ~(in_resp && !grant_like);
  assign halt_n_out = ~stall_req;
  assign bus_relinquish_request_n_out = ~stall_req;
  assign search_start_out = search_ff;
  assign modified_set_out = mset_ff;
  assign modified_page_out = mpage_ff;

  ////////////////////////////////////////////////////////////////////////////
  // root pointer table
  root_ptr_s rpt_ff [`RPT_NUM];
  root_ptr_s new_rp;
  logic [7:0] rpt_valid_ff;
  logic [7:0] rpt_hist_ff;
  logic [7:0] rpt_full_vec;
  logic [7:0] rpt_part_vec;
  logic [7:0] rpt_hist_pre;
  logic [2:0] full_idx;
  logic [2:0] part_idx;
  logic [2:0] rpt_vic_idx;
  logic rpt_vic_free;
  logic rpt_wr;

  assign new_rp = {reg_wdata_in, urp_hi_ff[`URP_LU_BIT], urp_hi_ff[30:16], urp_hi_ff[1:0]};

  for (genvar r = 0; r < `RPT_NUM; r++) begin : g_rpt
    assign rpt_full_vec[r] = rpt_valid_ff[r] && (rpt_ff[r] == new_rp);
    assign rpt_part_vec[r] = rpt_valid_ff[r] && (rpt_ff[r].addr == new_rp.addr)
      && (rpt_ff[r].lu == new_rp.lu);
    always_ff @(posedge ref_clk_in) begin
      if (rpt_wr && (rpt_new_idx == 3'(r))) begin
        rpt_ff[r] <= new_rp;
      end
    end
  end

  always_comb begin
    full_idx = 3'h0;
    part_idx = 3'h0;
    for (int i = `RPT_NUM - 1; i >= 0; i--) begin
      if (rpt_full_vec[i]) begin
        full_idx = 3'(i);
      end
      if (rpt_part_vec[i]) begin
        part_idx = 3'(i);
      end
    end
  end

  victim_picker #(
    .N(`RPT_NUM),
    .W(3)
  ) u_rpt_victim (
    .valid_in(rpt_valid_ff),
    .locked_in(8'h00),
    .recent_in(rpt_hist_ff),
    .idx_out(rpt_vic_idx),
    .found_out(),
    .invalid_out(rpt_vic_free)
  );

  wire full_hit = |rpt_full_vec;
  wire part_hit = |rpt_part_vec;
  assign rpt_wr = rp_load && !full_hit;
  assign rpt_new_idx = full_hit ? full_idx : (part_hit ? part_idx : rpt_vic_idx);
  assign rpt_kill = rpt_wr && (part_hit || !rpt_vic_free);
  wire [7:0] rpt_touch = rp_load ? (8'h01 << rpt_new_idx) : 8'h00;
  assign rpt_hist_pre = rpt_hist_ff | rpt_touch;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rpt_valid_ff <= 8'h00;
      rpt_hist_ff <= 8'h00;
      job_ff <= 3'h0;
      flush_ff <= 1'b0;
    end else begin
      rpt_valid_ff <= rpt_valid_ff | rpt_touch;
      rpt_hist_ff <= (&rpt_hist_pre) ? rpt_touch : rpt_hist_pre;
      if (rp_load) begin
        job_ff <= rpt_new_idx;
        flush_ff <= !full_hit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read-back
  always_comb begin
    if (reg_addr_in == `CTRL_OFS) begin
      rd_value = {28'h0000000, ctrl_ps_ff, ctrl_en_ff};
    end else if (reg_addr_in == `STATUS_OFS) begin
      rd_value = {{(24 - CW){1'b0}}, lock_cnt, 4'h0, flush_ff, job_ff};
    end else if (reg_addr_in == `URP_HI_OFS) begin
      rd_value = urp_hi_ff;
    end else if (reg_addr_in == `URP_LO_OFS) begin
      rd_value = rpt_ff[job_ff].addr;
    end else if (reg_addr_in == `FILL_TAG_OFS) begin
      rd_value = fill_tag_ff;
    end else if (reg_addr_in == `MISS_INFO_OFS) begin
      rd_value = {miss_info_ff[27:4], 4'h0, miss_info_ff[3:0]};
    end else begin
      rd_value = `RST_WORD;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_ff <= `RST_WORD;
    end else begin
      rdata_ff <= reg_rd_in ? rd_value : `RST_WORD;
    end
  end

  assign reg_rdata_out = rdata_ff;
endmodule

/* File: dv/xlat_cache_asserts.sv */
// port-level assertions for the translation cache
`timescale 1ns/1ps
module xlat_cache_asserts (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [31:0] logical_addr_in,
  input wire logic [3:0] function_code_in,
  input wire logic read_write_in,
  input wire logic logical_address_strobe_n_in,
  input wire logic read_modify_write_cycle_n_in,
  input wire logic timing_mode_select_in,
  input wire logic reg_select_in,
  input wire logic bus_owned_in,
  input wire logic [31:0] physical_addr_out,
  input wire logic physical_addr_strobe_n_out,
  input wire logic cache_inhibit_n_out,
  input wire logic bus_error_n_out,
  input wire logic halt_n_out,
  input wire logic bus_relinquish_request_n_out,
  input wire logic modified_set_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////
  sequence s_take_sync;
    $fell(logical_address_strobe_n_in) && !timing_mode_select_in;
  endsequence
  sequence s_take_timing_mode_select;
    $fell(logical_address_strobe_n_in) && timing_mode_select_in;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) rst_in |=> physical_addr_strobe_n_out
    && bus_error_n_out && halt_n_out) else $error("response active after reset");
  a_sync_not_early: assert property (s_take_sync |-> physical_addr_strobe_n_out [*4])
    else $error("synchronous strobe too early");
  a_timing_mode_select_not_early: assert property (s_take_timing_mode_select |-> physical_addr_strobe_n_out [*5])
    else $error("asynchronous strobe too early");
  a_error_after_wait: assert property ($fell(bus_error_n_out) && !timing_mode_select_in
    |-> $past(logical_address_strobe_n_in, 4) == 1'b0) else $error("bus error too early");
  a_halt_with_error: assert property ($fell(halt_n_out) |-> !bus_error_n_out
    && !bus_relinquish_request_n_out && read_modify_write_cycle_n_in)
    else $error("halt without bus error and relinquish");
  a_rmw_error_only: assert property (!bus_error_n_out && !read_modify_write_cycle_n_in
    |-> halt_n_out && bus_relinquish_request_n_out) else $error("halt during rmw miss");
  a_one_verdict: assert property (!physical_addr_strobe_n_out |-> bus_error_n_out)
    else $error("strobe and bus error together");
  a_strobe_needs_bus: assert property (!physical_addr_strobe_n_out |-> bus_owned_in)
    else $error("strobe without bus ownership");
  a_cpu_space_pass: assert property ($fell(physical_addr_strobe_n_out)
    && function_code_in == 4'h7 && !reg_select_in
    |-> !cache_inhibit_n_out && physical_addr_out == logical_addr_in)
    else $error("cpu space cycle not passed through");
  a_modified_on_write: assert property (modified_set_out |-> !read_write_in)
    else $error("modified pulse on a read");
endmodule
bind xlat_cache xlat_cache_asserts xlat_cache_asserts_i (.*);

/* File: dv/bus_master_model.sv */
// logical bus master model issuing one translated cycle at a time
`timescale 1ns/1ps
module bus_master_model (
  input wire logic ref_clk_in,
  input wire logic phys_strobe_n_in,
  input wire logic bus_err_n_in,
  input wire logic halt_n_in,
  input wire logic relinq_n_in,
  input wire logic inhibit_n_in,
  input wire logic [31:0] phys_addr_in,
  output logic [31:0] log_addr_out,
  output logic [3:0] func_code_out,
  output logic read_out,
  output logic log_strobe_n_out,
  output logic rmw_n_out,
  output logic timing_mode_out
);
  initial begin
    log_addr_out = 32'h0;
    func_code_out = 4'h0;
    read_out = 1'b1;
    log_strobe_n_out = 1'b1;
    rmw_n_out = 1'b1;
    timing_mode_out = 1'b0;
  end
  ////////////////////////////////////////
  // res: five response levels at the answer edge
  task automatic run(input logic [31:0] a, input logic [3:0] f, input bit w, rmw, md,
      output logic [4:0] res, output logic [31:0] pa);
    int n;
    res = 5'h1F;
    pa = 32'h0;
    @(posedge ref_clk_in);
    log_addr_out <= a;
    func_code_out <= f;
    read_out <= ~w;
    rmw_n_out <= ~rmw;
    timing_mode_out <= md;
    log_strobe_n_out <= 1'b0;
    // held until answered or 30 clocks pass: a late grant still completes
    for (n = 0; n < 30; n++) begin
      @(posedge ref_clk_in);
      if (phys_strobe_n_in === 1'b0 || bus_err_n_in === 1'b0) begin
        res = {phys_strobe_n_in, bus_err_n_in, halt_n_in, relinq_n_in, inhibit_n_in};
        pa = phys_addr_in;
        break;
      end
    end
    log_strobe_n_out <= 1'b1;
    for (n = 0; n < 30; n++) begin
      @(posedge ref_clk_in);
      if (phys_strobe_n_in === 1'b1 && bus_err_n_in === 1'b1) break;
    end
    // no stale address left on the bus between cycles
    log_addr_out <= ~a;
  endtask
endmodule

/* File: dv/tb_xlat_cache.sv */
// self-checking bench for the translation cache
`timescale 1ns/1ps
`include "xlat_cache_regs.svh"
module tb_xlat_cache;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic reg_select_in = 1'b0;
  logic self_master_in = 1'b0;
  logic bus_owned_in = 1'b1;
  logic [31:0] reg_rdata_out, logical_addr_in, physical_addr_out, pa;
  logic [3:0] function_code_in;
  logic [23:0] modified_page_out;
  logic read_write_in, logical_address_strobe_n_in, read_modify_write_cycle_n_in;
  logic timing_mode_select_in, physical_addr_strobe_n_out, cache_inhibit_n_out;
  logic bus_error_n_out, halt_n_out, bus_relinquish_request_n_out;
  logic search_start_out, modified_set_out;
  logic [4:0] res;
  logic [7:0] off;
  int miscompares = 0;
  int checked = 0;
  int mods = 0;
  int srch = 0;
  int i;
  localparam logic [31:0] HI = 32'h7FFF_0002;
  always #12.5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) if (modified_set_out === 1'b1) mods++;
  always @(posedge ref_clk_in) if (search_start_out === 1'b1) srch++;
  xlat_cache xlat_cache_i (.*);
  bus_master_model bus_master_model_i (.ref_clk_in,
    .phys_strobe_n_in(physical_addr_strobe_n_out), .bus_err_n_in(bus_error_n_out),
    .halt_n_in(halt_n_out), .relinq_n_in(bus_relinquish_request_n_out),
    .inhibit_n_in(cache_inhibit_n_out), .phys_addr_in(physical_addr_out),
    .log_addr_out(logical_addr_in), .func_code_out(function_code_in),
    .read_out(read_write_in), .log_strobe_n_out(logical_address_strobe_n_in),
    .rmw_n_out(read_modify_write_cycle_n_in), .timing_mode_out(timing_mode_select_in));
  ////////////////////////////////////////
  function automatic logic [31:0] st(input int job, fl, lk);
    return {17'h0, 7'(lk), 4'h0, 1'(fl), 3'(job)};
  endfunction
  function automatic logic [31:0] rsp(input bit hit, only, inh);
    return hit ? {27'h0, 4'b0111, ~inh} : {27'h0, 2'b10, only, only, 1'b1};
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge ref_clk_in);
    chk(reg_rdata_out, exp);
  endtask
  task automatic urp(input logic [31:0] hi, lo, exp);
    wr(`URP_HI_OFS, hi);
    wr(`URP_LO_OFS, lo);
    rd(`STATUS_OFS, exp);
  endtask
  task automatic fill(input logic [31:0] t, d);
    wr(`FILL_TAG_OFS, t);
    wr(`FILL_DATA_OFS, d);
  endtask
  task automatic cyc(input logic [31:0] a, input logic [3:0] f, input bit w, m, md,
      input logic [31:0] exp);
    bus_master_model_i.run(a, f, w, m, md, res, pa);
    chk({27'h0, res}, exp);
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    miscompares++;
    finish_test;
  end
  ////////////////////////////////////////
  initial begin
    i = $urandom(12562);
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(`STATUS_OFS, 32'h0);
    rd(8'hFC, 32'h0);
    wr(`CTRL_OFS, 32'h1);
    rd(`CTRL_OFS, 32'h1);
    urp(HI, 32'h0001_0000, st(0, 1, 0));
    urp(HI, 32'h0002_0000, st(1, 1, 0));
    urp(HI, 32'h0001_0000, st(0, 0, 0));
    fill(32'h0001_2305, 32'h0ABC_DE01);
    cyc(32'h0001_2334, 4'h5, 0, 0, 0, rsp(1, 0, 1));
    chk(pa, 32'h0ABC_DE34);
    cyc(32'h0099_9900, 4'h5, 0, 0, 0, rsp(0, 0, 0));
    rd(`MISS_INFO_OFS, 32'h0099_9905);
    cyc(32'h0099_9900, 4'h5, 1, 1, 0, rsp(0, 1, 0));
    cyc(32'hFFFF_1234, 4'h7, 0, 0, 0, rsp(1, 0, 1));
    chk(pa, 32'hFFFF_1234);
    reg_select_in <= 1'b1;
    cyc(32'hFFFF_1234, 4'h7, 0, 0, 0, 32'h1F);
    reg_select_in <= 1'b0;
    self_master_in <= 1'b1;
    cyc(32'h0001_2334, 4'h5, 0, 0, 0, 32'h1F);
    self_master_in <= 1'b0;
    fill(32'h0002_0005, 32'h0000_0010);
    cyc(32'h0002_0000, 4'h5, 0, 0, 0, rsp(0, 1, 0));
    fill(32'h0003_0005, 32'h0003_0000);
    cyc(32'h0003_0000, 4'h5, 1, 0, 0, rsp(1, 0, 0));
    cyc(32'h0003_0004, 4'h5, 1, 0, 0, rsp(1, 0, 0));
    chk(mods, 1);
    chk({8'h0, modified_page_out}, 32'h0000_0300);
    // upper-level write protect still denies
    fill(32'h0004_0045, 32'h0004_0000);
    cyc(32'h0004_0000, 4'h5, 1, 0, 0, rsp(0, 1, 0));
    cyc(32'h0004_0000, 4'h5, 0, 0, 0, rsp(1, 0, 0));
    urp(HI, 32'h0002_0000, st(1, 0, 0));
    cyc(32'h0001_2300, 4'h5, 0, 0, 0, rsp(0, 0, 0));
    fill(32'h0005_0085, 32'h0055_0000);
    urp(HI, 32'h0001_0000, st(0, 0, 0));
    cyc(32'h0005_0000, 4'h5, 0, 0, 0, rsp(1, 0, 0));
    cyc(32'h0005_0000, 4'h6, 0, 0, 0, rsp(0, 0, 0));
    cyc(32'h0001_2300, 4'h5, 0, 0, 0, rsp(1, 0, 1));
    urp(32'h7FFE_0002, 32'h0001_0000, st(0, 1, 0));
    cyc(32'h0001_2300, 4'h5, 0, 0, 0, rsp(0, 0, 0));
    cyc(32'h0005_0000, 4'h5, 0, 0, 0, rsp(1, 0, 0));
    fill(32'h0006_0005, 32'h0066_0000);
    fill(32'h0006_0005, 32'h0077_0000);
    cyc(32'h0006_0000, 4'h5, 0, 0, 0, rsp(0, 0, 0));
    cyc(32'h0006_0000, 4'h5, 0, 0, 0, rsp(0, 0, 0));
    bus_owned_in <= 1'b0;
    fork
      cyc(32'h0005_0000, 4'h5, 0, 0, 0, rsp(1, 0, 0));
      begin
        repeat (10) @(posedge ref_clk_in);
        bus_owned_in <= 1'b1;
      end
    join
    cyc(32'h0005_0000, 4'h5, 0, 0, 1, rsp(1, 0, 0));
    for (i = 0; i < 24; i++) begin
      off = 8'($urandom);
      cyc({24'h000500, off}, 4'h5, 1'($urandom), 0, 1'($urandom), rsp(1, 0, 0));
      chk(pa, {24'h005500, off});
    end
    cyc(32'h0005_0100, 4'h5, 0, 0, 0, rsp(0, 0, 0));
    wr(`CTRL_OFS, 32'h3);
    cyc(32'h0005_0100, 4'h5, 0, 0, 0, rsp(1, 0, 0));
    for (i = 0; i < 64; i++) fill({16'h0100, 8'(i), 8'h05}, 32'h0000_0008);
    rd(`STATUS_OFS, st(0, 1, 63));
    chk(srch, 7);
    finish_test;
  end
endmodule
